// file: design/pmbcb_bank.sv
// Maker command bank: peaks, delays, addressing, fault log, non-volatile settings and reset.
module pmbcb_bank
  import pmbcb_pkg::*;
#(
  parameter int unsigned         NCH       = 2,
  parameter int unsigned         LOG_DEPTH = 16,
  parameter int unsigned         CYC_MS    = CYC_PER_MS,
  parameter logic [15:0]         PART_ID   = 16'h5A30  // Arbitrary identity value.
)(
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_srst,
  // Command port
  input  wire pmbcb_req_t            i_req,
  input  wire logic [7:0]            i_log_idx,
  output logic                       o_rsp_valid,
  output logic [15:0]                o_rsp_data,
  output logic                       o_cml_err,
  // Save and restore of all settings
  input  wire logic                  i_store_all,
  input  wire logic                  i_restore_all,
  // Measurements
  input  wire logic                  i_meas_valid,
  input  wire logic [NCH-1:0][15:0]  i_iout,
  input  wire logic [NCH-1:0][15:0]  i_vout,
  input  wire logic [NCH-1:0][15:0]  i_temp1,
  input  wire logic [15:0]           i_vin,
  input  wire logic [15:0]           i_temp2,
  input  wire logic [15:0]           i_pad_state,
  input  wire logic [7:0]            i_common,
  // Working fault log
  input  wire logic                  i_log_we,
  input  wire logic [7:0]            i_log_addr,
  input  wire logic [7:0]            i_log_data,
  // Channel control
  input  wire logic [NCH-1:0]        i_fault,
  input  wire logic [NCH-1:0]        i_restart,
  output logic [NCH-1:0]             o_retry_hold,
  output logic [NCH-1:0]             o_run_low,
  // Settings to the core
  output logic                       o_cmp_mismatch,
  output logic                       o_soft_reset,
  output logic [7:0]                 o_dev_addr,
  output logic [7:0]                 o_pwm_cfg
);

  localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int LW  = $clog2(LOG_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  pmbcb_chan_nv_t chan_nv_reg  [NCH];
  pmbcb_chan_nv_t chan_nvm_reg [NCH];
  pmbcb_chan_nv_t chan_nv_next [NCH];
  pmbcb_dev_nv_t  dev_nv_reg;
  pmbcb_dev_nv_t  dev_nvm_reg;
  pmbcb_dev_nv_t  dev_nv_next;
  logic [15:0]    iout_pk_reg  [NCH];
  logic [15:0]    vout_pk_reg  [NCH];
  logic [15:0]    temp1_pk_reg [NCH];
  logic [15:0]    vin_pk_reg;
  logic [15:0]    temp2_pk_reg;
  logic [7:0]     log_work     [LOG_DEPTH];
  logic [7:0]     log_nvm      [LOG_DEPTH];
  logic [15:0]    rd_data;
  logic           rd_ok;
  logic           cmp_diff;
  logic           rsp_valid_reg;
  logic [15:0]    rsp_data_reg;
  logic           cml_err_reg;
  logic           cmp_reg;
  logic           soft_rst_reg;

  wire  [CHW-1:0] pg      = i_req.page[CHW-1:0];
  wire            pg_ok   = (i_req.page < 8'(NCH));
  wire            do_rd   = i_req.valid && !i_req.write && !i_req.send;
  wire            do_wr   = i_req.valid && i_req.write && !i_req.send;
  wire            do_snd  = i_req.valid && i_req.send;
  wire            is_clr  = do_snd && (i_req.code == CMD_CLR_PEAKS);
  wire            is_lst  = do_snd && (i_req.code == CMD_LOG_STORE);
  wire            is_lclr = do_snd && (i_req.code == CMD_LOG_CLEAR);
  wire            is_cmp  = do_snd && (i_req.code == CMD_COMPARE);
  wire            is_frst = do_snd && (i_req.code == CMD_FULL_RESET);
  wire            snd_ok  = is_clr || is_lst || is_lclr || is_cmp || is_frst;
  wire            wr_dev  = (i_req.code == CMD_DEV_ADDR) || (i_req.code == CMD_PWM_CFG);
  wire            wr_chan = (i_req.code == CMD_RETRY_DLY) || (i_req.code == CMD_RESTART_DLY)
                          || (i_req.code == CMD_SENSE_TC) || (i_req.code == CMD_TEMP1_SLOPE)
                          || (i_req.code == CMD_TEMP1_OFS) || (i_req.code == CMD_RAIL_ADDR);
  wire            wr_ok   = do_wr && (wr_dev || (wr_chan && pg_ok));
  // Reload from storage on restore or full reset; power-up is the reset branch.
  wire            load_nv = i_restore_all || is_frst;
  wire            pk_clr  = is_clr || is_frst;
  wire [LW-1:0]   rd_idx  = i_log_idx[LW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Write data per command; the two address bytes keep bit 7 as written only for the rail.
  always_comb
  begin
    dev_nv_next = dev_nv_reg;
    if (do_wr && i_req.code == CMD_DEV_ADDR)
      dev_nv_next.addr = i_req.data[7:0] & ADDR7_MASK;
    if (do_wr && i_req.code == CMD_PWM_CFG)
      dev_nv_next.pwm = i_req.data[7:0];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      dev_nv_reg  <= DEV_NV_DEF;
      dev_nvm_reg <= DEV_NV_DEF;
    end
    else
    begin
      dev_nv_reg <= load_nv ? dev_nvm_reg : dev_nv_next;
      if (i_store_all)
        dev_nvm_reg <= dev_nv_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per channel: settings, peaks and the two hold timers.
  logic [NCH-1:0] ch_diff;

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    wire sel = do_wr && pg_ok && (pg == CHW'(g));

    always_comb
    begin
      chan_nv_next[g] = chan_nv_reg[g];
      if (sel)
      begin
        case (i_req.code)
          CMD_RETRY_DLY:   chan_nv_next[g].retry    = i_req.data;
          CMD_RESTART_DLY: chan_nv_next[g].restart  = i_req.data;
          CMD_SENSE_TC:    chan_nv_next[g].sense_tc = i_req.data;
          CMD_TEMP1_SLOPE: chan_nv_next[g].t1_slope = i_req.data;
          CMD_TEMP1_OFS:   chan_nv_next[g].t1_ofs   = i_req.data;
          CMD_RAIL_ADDR:   chan_nv_next[g].rail     = i_req.data[7:0];
          default:         chan_nv_next[g] = chan_nv_reg[g];
        endcase
      end
    end

    always_ff @(posedge i_ref_clk)
    begin
      if (i_srst)
      begin
        chan_nv_reg[g]  <= CHAN_NV_DEF;
        chan_nvm_reg[g] <= CHAN_NV_DEF;
      end
      else
      begin
        chan_nv_reg[g] <= load_nv ? chan_nvm_reg[g] : chan_nv_next[g];
        if (i_store_all)
          chan_nvm_reg[g] <= chan_nv_reg[g];
      end
    end

    // A sample arriving with the clear starts the new peak, so it is not lost.
    always_ff @(posedge i_ref_clk)
    begin
      if (i_srst || (pk_clr && !i_meas_valid))
      begin
        iout_pk_reg[g]  <= PEAK_CLR_VAL;
        vout_pk_reg[g]  <= PEAK_CLR_VAL;
        temp1_pk_reg[g] <= PEAK_CLR_VAL;
      end
      else if (i_meas_valid)
      begin
        if (pk_clr || i_iout[g] > iout_pk_reg[g])
          iout_pk_reg[g] <= i_iout[g];
        if (pk_clr || i_vout[g] > vout_pk_reg[g])
          vout_pk_reg[g] <= i_vout[g];
        if (pk_clr || i_temp1[g] > temp1_pk_reg[g])
          temp1_pk_reg[g] <= i_temp1[g];
      end
    end

    assign ch_diff[g] = (chan_nv_reg[g] != chan_nvm_reg[g]);

    pmbcb_delay_timer #(.CYC_MS(CYC_MS)) u_retry (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst || is_frst),
      .i_start   (i_fault[g]),
      .i_ms      (pmbcb_l11_ms(chan_nv_reg[g].retry)),
      .o_busy    (o_retry_hold[g])
    );

    pmbcb_delay_timer #(.CYC_MS(CYC_MS)) u_restart (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst || is_frst),
      .i_start   (i_restart[g]),
      .i_ms      (pmbcb_l11_ms(chan_nv_reg[g].restart)),
      .o_busy    (o_run_low[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unpaged peaks.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || (pk_clr && !i_meas_valid))
    begin
      vin_pk_reg   <= PEAK_CLR_VAL;
      temp2_pk_reg <= PEAK_CLR_VAL;
    end
    else if (i_meas_valid)
    begin
      if (pk_clr || i_vin > vin_pk_reg)
        vin_pk_reg <= i_vin;
      if (pk_clr || i_temp2 > temp2_pk_reg)
        temp2_pk_reg <= i_temp2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault log: working copy written by the core, stored copy read back by block read.
  // Cleared at power-up so that a store before any fault never copies unknown bytes.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < LOG_DEPTH; i++)
        log_work[i] <= 8'h00;
    end
    else if (i_log_we && i_log_addr < 8'(LOG_DEPTH))
      log_work[i_log_addr[LW-1:0]] <= i_log_data;
  end

  // Storage is written a whole log at a time; a real array would need a sequencer here.
  always_ff @(posedge i_ref_clk)
  begin
    for (int i = 0; i < LOG_DEPTH; i++)
    begin
      if (i_srst || is_lclr)
        log_nvm[i] <= 8'h00;
      else if (is_lst)
        log_nvm[i] <= log_work[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.
  assign cmp_diff = (|ch_diff) || (dev_nv_reg != dev_nvm_reg);

  always_comb
  begin
    rd_ok   = pg_ok;
    rd_data = 16'h0000;
    case (i_req.code)
      CMD_IOUT_PEAK:   rd_data = iout_pk_reg[pg];
      CMD_VOUT_PEAK:   rd_data = vout_pk_reg[pg];
      CMD_TEMP1_PEAK:  rd_data = temp1_pk_reg[pg];
      CMD_RETRY_DLY:   rd_data = chan_nv_reg[pg].retry;
      CMD_RESTART_DLY: rd_data = chan_nv_reg[pg].restart;
      CMD_SENSE_TC:    rd_data = chan_nv_reg[pg].sense_tc;
      CMD_TEMP1_SLOPE: rd_data = chan_nv_reg[pg].t1_slope;
      CMD_TEMP1_OFS:   rd_data = chan_nv_reg[pg].t1_ofs;
      CMD_RAIL_ADDR:   rd_data = {8'h00, chan_nv_reg[pg].rail};
      default:
      begin
        rd_ok = 1'b1;
        case (i_req.code)
          CMD_VIN_PEAK:   rd_data = vin_pk_reg;
          CMD_TEMP2_PEAK: rd_data = temp2_pk_reg;
          CMD_PAD_STATE:  rd_data = i_pad_state;
          CMD_DEV_ADDR:   rd_data = {8'h00, dev_nv_reg.addr};
          CMD_PART_ID:    rd_data = PART_ID;
          CMD_COMMON:     rd_data = {8'h00, i_common};
          CMD_PWM_CFG:    rd_data = {8'h00, dev_nv_reg.pwm};
          CMD_LOG_BLOCK:  rd_data = (i_log_idx < 8'(LOG_DEPTH)) ? {8'h00, log_nvm[rd_idx]} : 16'h0000;
          default:        rd_ok = 1'b0;
        endcase
      end
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= 16'h0000;
      cml_err_reg   <= 1'b0;
      cmp_reg       <= 1'b0;
      soft_rst_reg  <= 1'b0;
    end
    else
    begin
      rsp_valid_reg <= do_rd && rd_ok;
      rsp_data_reg  <= (do_rd && rd_ok) ? rd_data : 16'h0000;
      cml_err_reg   <= (do_rd && !rd_ok) || (do_wr && !wr_ok) || (do_snd && !snd_ok);
      cmp_reg       <= is_cmp ? cmp_diff : cmp_reg;
      soft_rst_reg  <= is_frst;
    end
  end

  assign o_rsp_valid    = rsp_valid_reg;
  assign o_rsp_data     = rsp_data_reg;
  assign o_cml_err      = cml_err_reg;
  assign o_cmp_mismatch = cmp_reg;
  assign o_soft_reset   = soft_rst_reg;
  assign o_dev_addr     = dev_nv_reg.addr;
  assign o_pwm_cfg      = dev_nv_reg.pwm;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  a_peak_no_drop: assert property (!pk_clr |=> vin_pk_reg >= $past(vin_pk_reg))
    else $error("Input voltage peak fell without a clear.");
  a_peak_clear: assert property (pk_clr && !i_meas_valid |=> vin_pk_reg == PEAK_CLR_VAL)
    else $error("Peak not cleared.");
  a_addr_seven: assert property (dev_nv_reg.addr[7] == 1'b0)
    else $error("Device address exceeds seven bits.");
  a_ro_unchanged: assert property (do_wr && i_req.code == CMD_PART_ID && !load_nv
                                   |=> o_cml_err && $stable(dev_nv_reg))
    else $error("Read-only write not refused.");
  a_restore_load: assert property (load_nv |=> dev_nv_reg == $past(dev_nvm_reg))
    else $error("Settings not reloaded.");
  a_reset_pulse: assert property (is_frst |=> o_soft_reset ##1 !o_soft_reset || $past(is_frst, 1))
    else $error("Full reset not signalled.");
  a_log_clear: assert property (is_lclr |=> log_nvm[0] == 8'h00)
    else $error("Stored log not cleared.");
  a_log_store: assert property (is_lst && !i_srst |=> log_nvm[0] == $past(log_work[0]))
    else $error("Log not stored.");
  // Only holds of eight cycles or more are checked; a full reset may cut any hold short.
  a_run_low: assert property (disable iff (i_srst || is_frst)
                              i_restart[0] && pmbcb_l11_ms(chan_nv_reg[0].restart) * CYC_MS >= 8
                              |=> o_run_low[0] [*8])
    else $error("Run not held low.");
  a_compare: assert property (is_cmp |=> o_cmp_mismatch == $past(cmp_diff))
    else $error("Compare result wrong.");
  a_pwm_write: assert property (do_wr && i_req.code == CMD_PWM_CFG && !load_nv
                                |=> o_pwm_cfg == $past(i_req.data[7:0]))
    else $error("PWM byte not written.");

  c_peak_clear: cover property (is_clr ##1 i_meas_valid);
  c_store_restore: cover property (i_store_all ##[1:20] i_restore_all);
  c_run_low_end: cover property ($fell(o_run_low[0]));

endmodule // pmbcb_bank

// file: design/pmbcb_delay_timer.sv
// Millisecond hold timer: busy from a start pulse for a given number of whole milliseconds.
module pmbcb_delay_timer
  import pmbcb_pkg::*;
#(
  parameter int unsigned CYC_MS = CYC_PER_MS
)(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // Control
  input  wire logic        i_start,
  input  wire logic [15:0] i_ms,
  // Status
  output logic             o_busy
);

  localparam int CW = $clog2(CYC_MS + 1);

  logic [CW-1:0] cyc_reg;
  logic [15:0]   ms_reg;
  logic          busy_reg;
  wire           ms_edge = (cyc_reg == CW'(CYC_MS - 1));
  wire           last_ms = (ms_reg <= 16'h0001);

  // The cycle count restarts with each start so a full millisecond is always spent.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      cyc_reg  <= '0;
      ms_reg   <= 16'h0000;
      busy_reg <= 1'b0;
    end
    else if (i_start)
    begin
      cyc_reg  <= '0;
      ms_reg   <= i_ms;
      busy_reg <= (i_ms != 16'h0000);
    end
    else if (busy_reg)
    begin
      cyc_reg  <= ms_edge ? '0 : CW'(cyc_reg + 1'b1);
      ms_reg   <= ms_edge ? 16'(ms_reg - 1'b1) : ms_reg;
      busy_reg <= !(ms_edge && last_ms);
    end
  end

  assign o_busy = busy_reg;

endmodule // pmbcb_delay_timer

// file: design/pmbcb_pkg.sv
// Command codes, defaults, timing constants and carrier types of the maker command bank.
package pmbcb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0]  CMD_IOUT_PEAK   = 8'hD7;
  localparam logic [7:0]  CMD_RETRY_DLY   = 8'hDB;
  localparam logic [7:0]  CMD_RESTART_DLY = 8'hDC;
  localparam logic [7:0]  CMD_VOUT_PEAK   = 8'hDD;
  localparam logic [7:0]  CMD_VIN_PEAK    = 8'hDE;
  localparam logic [7:0]  CMD_TEMP1_PEAK  = 8'hDF;
  localparam logic [7:0]  CMD_CLR_PEAKS   = 8'hE3;
  localparam logic [7:0]  CMD_PAD_STATE   = 8'hE5;
  localparam logic [7:0]  CMD_DEV_ADDR    = 8'hE6;
  localparam logic [7:0]  CMD_PART_ID     = 8'hE7;
  localparam logic [7:0]  CMD_LOG_STORE   = 8'hEA;
  localparam logic [7:0]  CMD_LOG_CLEAR   = 8'hEC;
  localparam logic [7:0]  CMD_LOG_BLOCK   = 8'hEE;
  localparam logic [7:0]  CMD_COMMON      = 8'hEF;
  localparam logic [7:0]  CMD_COMPARE     = 8'hF0;
  localparam logic [7:0]  CMD_TEMP2_PEAK  = 8'hF4;
  localparam logic [7:0]  CMD_PWM_CFG     = 8'hF5;
  localparam logic [7:0]  CMD_SENSE_TC    = 8'hF6;
  localparam logic [7:0]  CMD_TEMP1_SLOPE = 8'hF8;
  localparam logic [7:0]  CMD_TEMP1_OFS   = 8'hF9;
  localparam logic [7:0]  CMD_RAIL_ADDR   = 8'hFA;
  localparam logic [7:0]  CMD_FULL_RESET  = 8'hFD;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] RETRY_DLY_DEF   = 16'hFABC;
  localparam logic [15:0] RESTART_DLY_DEF = 16'hFBE8;
  localparam logic [7:0]  DEV_ADDR_DEF    = 8'h4F;
  localparam logic [7:0]  PWM_CFG_DEF     = 8'h14;
  localparam logic [15:0] SENSE_TC_DEF    = 16'h0F3C;
  localparam logic [15:0] TEMP1_SLOPE_DEF = 16'h4000;
  localparam logic [15:0] TEMP1_OFS_DEF   = 16'h8000;
  localparam logic [7:0]  RAIL_ADDR_DEF   = 8'h80;
  localparam logic [7:0]  ADDR7_MASK      = 8'h7F;
  localparam logic [15:0] PEAK_CLR_VAL    = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        send;
    logic [7:0]  page;
    logic [7:0]  code;
    logic [15:0] data;
  } pmbcb_req_t;

  typedef struct packed {
    logic [15:0] retry;
    logic [15:0] restart;
    logic [15:0] sense_tc;
    logic [15:0] t1_slope;
    logic [15:0] t1_ofs;
    logic [7:0]  rail;
  } pmbcb_chan_nv_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] pwm;
  } pmbcb_dev_nv_t;

  localparam pmbcb_chan_nv_t CHAN_NV_DEF = '{RETRY_DLY_DEF, RESTART_DLY_DEF, SENSE_TC_DEF,
                                             TEMP1_SLOPE_DEF, TEMP1_OFS_DEF, RAIL_ADDR_DEF};
  localparam pmbcb_dev_nv_t  DEV_NV_DEF  = '{DEV_ADDR_DEF, PWM_CFG_DEF};

  // Linear 11-bit to whole milliseconds; negative values give zero, fractions are dropped.
  function automatic logic [15:0] pmbcb_l11_ms(input logic [15:0] v);
    logic signed [4:0] ex;
    logic [10:0]       mt;
    ex = v[15:11];
    mt = v[10:0];
    if (mt[10])
      return 16'h0000;
    else if (ex < 0)
      return 16'({5'h00, mt} >> (-ex));
    else
      return 16'({5'h00, mt} << ex);
  endfunction

endpackage

// file: testbench/pmbcb_host_model.sv
// Host model that issues one command-port request at a time.
module pmbcb_host_model
  import pmbcb_pkg::*;
(
  // Clock
  input  wire logic i_ref_clk,
  // Requests
  output pmbcb_req_t o_req,
  output logic [7:0] o_log_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_req = '0;
    o_log_idx = 8'h00;
  end
  // Idle lines carry the inverse of the last request, so stale fields never pass for a command.
  task automatic xfer(input logic w, s, input logic [7:0] pg, cd, input logic [15:0] dt, input logic [7:0] ix);
    pmbcb_req_t r;
    r = '{1'b1, w, s, s ? 8'h00 : pg, cd, dt};
    @(posedge i_ref_clk);
    o_req <= r;
    o_log_idx <= ix;
    @(posedge i_ref_clk);
    r = ~r;
    r.valid = 1'b0;
    o_req <= r;
    o_log_idx <= ~ix;
  endtask
endmodule // pmbcb_host_model

// file: testbench/tb_pmbcb_bank.sv
// Self-checking bench for the maker command bank.
module tb_pmbcb_bank
  import pmbcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ID = 16'h3C71;  // Arbitrary identity value.
  logic             i_ref_clk = 1'b0;
  logic             i_srst = 1'b1;
  pmbcb_req_t       i_req;
  logic [7:0]       i_log_idx, i_log_addr, i_log_data, i_common, o_dev_addr, o_pwm_cfg;
  logic             i_store_all, i_restore_all, i_meas_valid, i_log_we, o_rsp_valid, o_cml_err;
  logic             o_cmp_mismatch, o_soft_reset;
  logic [1:0][15:0] i_iout, i_vout, i_temp1;
  logic [15:0]      i_vin, i_temp2, i_pad_state, o_rsp_data, wv [6][2];
  logic [1:0]       i_fault, i_restart, o_retry_hold, o_run_low;
  logic [7:0][15:0] mx, m;
  logic [16:0]      q [$];
  logic [7:0]       rw [6] = '{CMD_RETRY_DLY, CMD_RESTART_DLY, CMD_SENSE_TC, CMD_TEMP1_SLOPE, CMD_TEMP1_OFS,
                               CMD_RAIL_ADDR};
  logic [7:0]       pc [8] = '{CMD_IOUT_PEAK, CMD_IOUT_PEAK, CMD_VOUT_PEAK, CMD_VOUT_PEAK, CMD_TEMP1_PEAK,
                               CMD_TEMP1_PEAK, CMD_VIN_PEAK, CMD_TEMP2_PEAK};
  int               n_mismatch = 0, checks = 0, cyc = 0, n_rst = 0, n0, n1, n2;
  pmbcb_host_model host (.i_ref_clk, .o_req(i_req), .o_log_idx(i_log_idx));
  pmbcb_bank #(.CYC_MS(4), .PART_ID(ID)) dut (.i_ref_clk, .i_srst, .i_req, .i_log_idx, .o_rsp_valid, .o_rsp_data,
    .o_cml_err, .i_store_all, .i_restore_all, .i_meas_valid, .i_iout, .i_vout, .i_temp1, .i_vin, .i_temp2,
    .i_pad_state, .i_common, .i_log_we, .i_log_addr, .i_log_data, .i_fault, .i_restart, .o_retry_hold,
    .o_run_low, .o_cmp_mismatch, .o_soft_reset, .o_dev_addr, .o_pwm_cfg);
  always #25 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////
  task automatic check(input logic [16:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Kind k is 0 for no answer, 1 for a read answer and 2 for a refusal.
  task automatic cmd(input logic w, s, input logic [7:0] pg, cd, input logic [15:0] dt, input int k,
                     input logic [7:0] ix = 8'h00);
    if (k != 0)
      q.push_back(k == 2 ? 17'h10000 : {1'b0, dt});
    host.xfer(w, s, pg, cd, dt, ix);
  endtask
  task automatic rd(input logic [7:0] pg, cd, input logic [15:0] e, input logic [7:0] ix = 8'h00);
    cmd(1'b0, 1'b0, pg, cd, e, 1, ix);
  endtask
  task automatic wr(input logic [7:0] pg, cd, input logic [15:0] dt);
    cmd(1'b1, 1'b0, pg, cd, dt, 0);
  endtask
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (o_soft_reset === 1'b1)
      n_rst++;
    if (o_rsp_valid === 1'b1 || o_cml_err === 1'b1)
      check({o_cml_err, o_rsp_data}, q.size() > 0 ? q.pop_front() : 17'h1FFFF);
    if (cyc == 4000)
    begin
      n_mismatch++;
      results();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h91F40E14));
    {i_store_all, i_restore_all, i_meas_valid, i_log_we, i_fault, i_restart, i_log_addr} = '0;
    {i_iout, i_vout, i_temp1, i_vin, i_temp2, i_log_data, mx} = '0;
    i_pad_state = 16'($urandom);
    i_common = 8'($urandom);
    repeat (4) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rd(8'h00, CMD_RETRY_DLY, 16'hFABC);
    rd(8'h01, CMD_RESTART_DLY, 16'hFBE8);
    rd(8'h00, CMD_DEV_ADDR, 16'h004F);
    rd(8'h01, CMD_RAIL_ADDR, 16'h0080);
    rd(8'h00, CMD_PWM_CFG, 16'h0014);
    rd(8'h01, CMD_SENSE_TC, 16'h0F3C);
    rd(8'h00, CMD_TEMP1_SLOPE, 16'h4000);
    rd(8'h01, CMD_TEMP1_OFS, 16'h8000);
    rd(8'h00, CMD_PART_ID, ID);
    rd(8'h00, CMD_PAD_STATE, i_pad_state);
    rd(8'h00, CMD_COMMON, {8'h00, i_common});
    for (int j = 0; j < 6; j++)
    begin
      for (int p = 0; p < 2; p++)
      begin
        wv[j][p] = 16'($urandom);
        if (rw[j] == CMD_RAIL_ADDR)
          wv[j][p][15:8] = 8'h00;
        wr(8'(p), rw[j], wv[j][p]);
      end
      for (int p = 0; p < 2; p++)
        rd(8'(p), rw[j], wv[j][p]);
    end
    cmd(1'b1, 1'b0, 8'h00, CMD_IOUT_PEAK, 16'h1234, 2);
    cmd(1'b1, 1'b0, 8'h00, CMD_PART_ID, 16'h1234, 2);
    cmd(1'b1, 1'b0, 8'h00, 8'hD8, 16'h1234, 2);
    cmd(1'b0, 1'b0, 8'h00, CMD_LOG_STORE, 16'h0000, 2);
    cmd(1'b0, 1'b1, 8'h00, CMD_RETRY_DLY, 16'h0000, 2);
    cmd(1'b1, 1'b0, 8'h02, CMD_RETRY_DLY, 16'h1234, 2);
    rd(8'h00, CMD_PART_ID, ID);
    rd(8'h00, CMD_RETRY_DLY, wv[0][0]);
    rd(8'h01, CMD_RETRY_DLY, wv[0][1]);
    wr(8'h00, CMD_DEV_ADDR, 16'h00FF);
    rd(8'h00, CMD_DEV_ADDR, 16'h007F);
    check({9'h000, o_dev_addr}, 17'h0007F);
    repeat (6)
    begin
      for (int k = 0; k < 8; k++)
      begin
        m[k] = 16'($urandom);
        if (m[k] > mx[k])
          mx[k] = m[k];
      end
      @(posedge i_ref_clk);
      {i_temp2, i_vin, i_temp1, i_vout, i_iout, i_meas_valid} <= {m, 1'b1};
      @(posedge i_ref_clk);
      i_meas_valid <= 1'b0;
    end
    for (int k = 0; k < 8; k++)
      rd(8'(k % 2), pc[k], mx[k]);
    cmd(1'b0, 1'b1, 8'h01, CMD_CLR_PEAKS, 16'h0000, 0);
    for (int k = 0; k < 8; k++)
      rd(8'(k % 2), pc[k], 16'h0000);
    @(posedge i_ref_clk);
    {i_log_we, i_log_addr, i_log_data} <= {1'b1, 8'h03, m[0][7:0] | 8'h01};
    @(posedge i_ref_clk);
    i_log_we <= 1'b0;
    rd(8'h00, CMD_LOG_BLOCK, 16'h0000, 8'h03);
    cmd(1'b0, 1'b1, 8'h00, CMD_LOG_STORE, 16'h0000, 0);
    rd(8'h00, CMD_LOG_BLOCK, {8'h00, m[0][7:0] | 8'h01}, 8'h03);
    cmd(1'b0, 1'b1, 8'h00, CMD_LOG_CLEAR, 16'h0000, 0);
    rd(8'h00, CMD_LOG_BLOCK, 16'h0000, 8'h03);
    wr(8'h00, CMD_PWM_CFG, 16'h0033);
    cmd(1'b0, 1'b1, 8'h00, CMD_COMPARE, 16'h0000, 0);
    @(posedge i_ref_clk);
    check(17'(o_cmp_mismatch), 17'h00001);
    i_store_all <= 1'b1;
    @(posedge i_ref_clk);
    i_store_all <= 1'b0;
    cmd(1'b0, 1'b1, 8'h00, CMD_COMPARE, 16'h0000, 0);
    @(posedge i_ref_clk);
    check(17'(o_cmp_mismatch), 17'h00000);
    wr(8'h00, CMD_PWM_CFG, 16'h005A);
    @(posedge i_ref_clk);
    check({9'h000, o_pwm_cfg}, 17'h0005A);
    i_restore_all <= 1'b1;
    @(posedge i_ref_clk);
    i_restore_all <= 1'b0;
    rd(8'h00, CMD_PWM_CFG, 16'h0033);
    wr(8'h00, CMD_PWM_CFG, 16'h005A);
    wr(8'h00, CMD_DEV_ADDR, 16'h0011);
    cmd(1'b0, 1'b1, 8'h00, CMD_FULL_RESET, 16'h0000, 0);
    rd(8'h00, CMD_PWM_CFG, 16'h0033);
    rd(8'h00, CMD_DEV_ADDR, 16'h007F);
    check(17'(n_rst), 17'h00001);
    wr(8'h00, CMD_RESTART_DLY, 16'h0002);
    wr(8'h01, CMD_RETRY_DLY, 16'h0001);
    @(posedge i_ref_clk);
    {i_restart, i_fault} <= 4'h6;
    @(posedge i_ref_clk);
    {i_restart, i_fault, n0, n1, n2} <= '0;
    repeat (16)
    begin
      @(posedge i_ref_clk);
      n0 += o_run_low[0];
      n1 += o_retry_hold[1];
      n2 += o_run_low[1] + o_retry_hold[0];
    end
    check(17'(n0), 17'h00008);
    check(17'(n1), 17'h00004);
    check(17'(n2), 17'h00000);
    check(17'(q.size()), 17'h00000);
    results();
  end
endmodule // tb_pmbcb_bank
